/* rtl/bct_debounce.sv */
// Two-stage synchroniser and stability filter for a group of switch inputs.
// Assumes inputs are asynchronous switch levels; outputs are clean levels.
`timescale 1ns/1ps
`default_nettype none
module bct_debounce
    import bct_pkg::*;
#(
    parameter int               N   = N_IN,
    parameter logic [DEB_W-1:0] CYC = DEB_CYC
)(
    input  wire logic         clk_sys_i,
    input  wire logic         rst_n_i,
    input  wire logic [N-1:0] raw_i,
    output logic      [N-1:0] clean_o
);
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_bit
            logic             meta_q;
            logic             sync_q;
            logic [DEB_W-1:0] cnt_q;
            always_ff @(posedge clk_sys_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end
                else
                begin
                    meta_q <= raw_i[g];
                    sync_q <= meta_q;
                end
            end
            // A level must hold for the whole window so contact bounce never makes an edge.
            always_ff @(posedge clk_sys_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                begin
                    cnt_q      <= '0;
                    clean_o[g] <= 1'b0;
                end
                else if (sync_q == clean_o[g])
                    cnt_q <= '0;
                else if (cnt_q >= CYC - 1'b1)
                begin
                    cnt_q      <= '0;
                    clean_o[g] <= sync_q;
                end
                else
                    cnt_q <= cnt_q + 1'b1;
            end
        end
    endgenerate
endmodule
`default_nettype wire

/* rtl/bct_pkg.sv */
// Shared constants for the body control timer block: input indices, times and
// the cycle counts derived from them.
// Assumes a 100 MHz system clock.
`default_nettype none
package bct_pkg;
    localparam int unsigned CLK_HZ     = 100_000_000;
    localparam longint      CYC_PER_MS = longint'(CLK_HZ) / 64'd1000;
    localparam int TMR_W = 40;
    localparam int DEB_W = 24;
    localparam int PWM_W = 8;

    localparam int N_IN      = 12;
    localparam int IN_IGN    = 0;
    localparam int IN_KEY    = 1;
    localparam int IN_DRV    = 2;
    localparam int IN_PASS   = 3;
    localparam int IN_REAR   = 4;
    localparam int IN_LIFT   = 5;
    localparam int IN_DSEL   = 6;
    localparam int IN_DLOCK  = 7;
    localparam int IN_PLOCK  = 8;
    localparam int IN_KCYL   = 9;
    localparam int IN_DEFOG  = 10;
    localparam int IN_BUCKLE = 11;

    localparam longint DEB_MS         = 10;
    localparam longint UNLOCK_LONG_MS = 5000;
    localparam longint PULSE_MS       = 500;
    localparam longint ILLUM_MS       = 10000;
    localparam longint DIM_MS         = 6000;
    localparam longint DEFOG_MS       = 660000;
    localparam longint BELT_MS        = 6000;
    localparam longint BELT_HALF_MS   = 750;
    localparam longint BUZZ_HALF_MS   = 250;

    localparam logic [DEB_W-1:0] DEB_CYC         = DEB_W'(DEB_MS * CYC_PER_MS);
    localparam logic [TMR_W-1:0] UNLOCK_LONG_CYC = TMR_W'(UNLOCK_LONG_MS * CYC_PER_MS);
    localparam logic [TMR_W-1:0] PULSE_CYC       = TMR_W'(PULSE_MS * CYC_PER_MS);
    localparam logic [TMR_W-1:0] ILLUM_CYC       = TMR_W'(ILLUM_MS * CYC_PER_MS);
    localparam logic [TMR_W-1:0] DIM_STEP_CYC    = TMR_W'((DIM_MS * CYC_PER_MS) / 64'd255);
    localparam logic [TMR_W-1:0] DEFOG_CYC       = TMR_W'(DEFOG_MS * CYC_PER_MS);
    localparam logic [TMR_W-1:0] BELT_CYC        = TMR_W'(BELT_MS * CYC_PER_MS);
    localparam logic [TMR_W-1:0] BELT_HALF_CYC   = TMR_W'(BELT_HALF_MS * CYC_PER_MS);
    localparam logic [TMR_W-1:0] BUZZ_HALF_CYC   = TMR_W'(BUZZ_HALF_MS * CYC_PER_MS);

    localparam logic [PWM_W-1:0] DIM_FULL = 8'hff;
    localparam logic [PWM_W-1:0] DIM_OFF  = 8'h00;

    typedef enum logic [2:0] {
        DIM_IDLE = 3'b001,
        DIM_LIT  = 3'b010,
        DIM_RAMP = 3'b100
    } bct_dim_e;
endpackage
`default_nettype wire

/* rtl/bct_timer.sv */
// One-shot interval timer: runs for CYC cycles after a start while idle.
// Assumes start and stop are synchronous; stop wins over start.
`timescale 1ns/1ps
`default_nettype none
module bct_timer
    import bct_pkg::*;
#(
    parameter logic [TMR_W-1:0] CYC = PULSE_CYC
)(
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    input  wire logic start_i,
    input  wire logic stop_i,
    output logic      run_o
);
    logic [TMR_W-1:0] cnt_q;

    // A start while running is dropped, so the interval is never stretched.
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            run_o <= 1'b0;
            cnt_q <= '0;
        end
        else if (stop_i)
            run_o <= 1'b0;
        else if (!run_o && start_i)
        begin
            run_o <= 1'b1;
            cnt_q <= CYC - 1'b1;
        end
        else if (run_o)
        begin
            if (cnt_q == '0)
                run_o <= 1'b0;
            else
                cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule
`default_nettype wire

/* rtl/bct_timers.sv */
// Body control timers: door lock pulses, key and belt alarms, lamp timers and defogger.
// Assumes a free-running 100 MHz clock and switch inputs straight from the vehicle.
`timescale 1ns/1ps
`default_nettype none
module bct_timers
    import bct_pkg::*;
#(
    parameter logic [DEB_W-1:0] P_DEB_CYC         = DEB_CYC,
    parameter logic [TMR_W-1:0] P_UNLOCK_LONG_CYC = UNLOCK_LONG_CYC,
    parameter logic [TMR_W-1:0] P_PULSE_CYC       = PULSE_CYC,
    parameter logic [TMR_W-1:0] P_ILLUM_CYC       = ILLUM_CYC,
    parameter logic [TMR_W-1:0] P_DIM_STEP_CYC    = DIM_STEP_CYC,
    parameter logic [TMR_W-1:0] P_DEFOG_CYC       = DEFOG_CYC,
    parameter logic [TMR_W-1:0] P_BELT_CYC        = BELT_CYC,
    parameter logic [TMR_W-1:0] P_BELT_HALF_CYC   = BELT_HALF_CYC,
    parameter logic [TMR_W-1:0] P_BUZZ_HALF_CYC   = BUZZ_HALF_CYC
)(
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    input  wire logic ign_on_i,
    input  wire logic key_in_i,
    input  wire logic door_drv_open_i,
    input  wire logic door_pass_open_i,
    input  wire logic door_rear_open_i,
    input  wire logic liftgate_open_i,
    input  wire logic dome_door_sel_i,
    input  wire logic lock_drv_locked_i,
    input  wire logic lock_pass_locked_i,
    input  wire logic key_cyl_unlock_i,
    input  wire logic defog_sw_i,
    input  wire logic belt_buckled_i,
    output logic      unlock_driver_output_o,
    output logic      lock_or_lamp_driver_output_o,
    output logic      unlock_or_buzzer_driver_output_o,
    output logic      buzzer_o,
    output logic      ign_illum_o,
    output logic      dome_light_o,
    output logic      foot_light_o,
    output logic      defog_relay_o,
    output logic      belt_light_o
);
    logic [N_IN-1:0] sw;
    logic [N_IN-1:0] prev_q;
    logic [N_IN-1:0] rise;

    // Nothing below looks at a raw pin.
    bct_debounce #(
        .N   (N_IN),
        .CYC (P_DEB_CYC)
    ) u_deb (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .raw_i     ({belt_buckled_i, defog_sw_i, key_cyl_unlock_i, lock_pass_locked_i,
                     lock_drv_locked_i, dome_door_sel_i, liftgate_open_i, door_rear_open_i,
                     door_pass_open_i, door_drv_open_i, key_in_i, ign_on_i}),
        .clean_o   (sw)
    );

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            prev_q <= '0;
        else
            prev_q <= sw;
    end

    assign rise = sw & ~prev_q;

    logic ign;
    logic key;
    logic front_open;
    logic any_open;
    logic foot_zone_open;
    logic all_closed;

    assign ign            = sw[IN_IGN];
    assign key            = sw[IN_KEY];
    assign front_open     = sw[IN_DRV] | sw[IN_PASS];
    assign any_open       = front_open | sw[IN_REAR] | sw[IN_LIFT];
    assign foot_zone_open = front_open | sw[IN_LIFT];
    assign all_closed     = !any_open;

    // Door lock group.
    logic unlock_long_start;
    logic unlock_short_start;
    logic lock_start;
    logic unlock_long_run;
    logic unlock_short_run;
    logic lock_run;

    assign unlock_long_start = (key && front_open && rise[IN_DLOCK])
                             || (key && sw[IN_DLOCK] && sw[IN_PASS] && rise[IN_PLOCK]);
    assign lock_start = (!key || all_closed) && rise[IN_DLOCK];
    assign unlock_short_start = !sw[IN_DLOCK] && rise[IN_KCYL];

    bct_timer #(
        .CYC (P_UNLOCK_LONG_CYC)
    ) u_unlock_long (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .start_i   (unlock_long_start),
        .stop_i    (1'b0),
        .run_o     (unlock_long_run)
    );

    bct_timer #(
        .CYC (P_PULSE_CYC)
    ) u_unlock_short (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .start_i   (unlock_short_start),
        .stop_i    (1'b0),
        .run_o     (unlock_short_run)
    );

    bct_timer #(
        .CYC (P_PULSE_CYC)
    ) u_lock (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .start_i   (lock_start),
        .stop_i    (1'b0),
        .run_o     (lock_run)
    );

    // Ignition illumination.
    logic illum_run;

    bct_timer #(
        .CYC (P_ILLUM_CYC)
    ) u_illum (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .start_i   (rise[IN_DRV] && !ign),
        .stop_i    (ign),
        .run_o     (illum_run)
    );

    // Defogger: a fresh press either starts or stops; the release is not an event.
    logic defog_run;
    logic defog_press;

    assign defog_press = rise[IN_DEFOG];

    bct_timer #(
        .CYC (P_DEFOG_CYC)
    ) u_defog (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .start_i   (defog_press && ign),
        .stop_i    (!ign || (defog_press && defog_run)),
        .run_o     (defog_run)
    );

    // Seat belt warning.
    logic belt_light_run;
    logic belt_buzz_run;

    bct_timer #(
        .CYC (P_BELT_CYC)
    ) u_belt_light (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .start_i   (rise[IN_IGN]),
        .stop_i    (!ign),
        .run_o     (belt_light_run)
    );

    bct_timer #(
        .CYC (P_BELT_CYC)
    ) u_belt_buzz (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .start_i   (rise[IN_IGN] && !sw[IN_BUCKLE]),
        .stop_i    (!ign || sw[IN_BUCKLE]),
        .run_o     (belt_buzz_run)
    );

    // Blink phase for the warning light, restarted with the ignition edge.
    logic [TMR_W-1:0] blink_cnt_q;
    logic             blink_q;

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            blink_cnt_q <= '0;
            blink_q     <= 1'b0;
        end
        else if (rise[IN_IGN])
        begin
            blink_cnt_q <= '0;
            blink_q     <= 1'b1;
        end
        else if (blink_cnt_q >= P_BELT_HALF_CYC - 1'b1)
        begin
            blink_cnt_q <= '0;
            blink_q     <= !blink_q;
        end
        else
            blink_cnt_q <= blink_cnt_q + 1'b1;
    end

    // Free-running tone cadence shared by both buzzer sources.
    logic [TMR_W-1:0] buzz_cnt_q;
    logic             buzz_q;

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            buzz_cnt_q <= '0;
            buzz_q     <= 1'b0;
        end
        else if (buzz_cnt_q >= P_BUZZ_HALF_CYC - 1'b1)
        begin
            buzz_cnt_q <= '0;
            buzz_q     <= !buzz_q;
        end
        else
            buzz_cnt_q <= buzz_cnt_q + 1'b1;
    end

    logic key_alarm;

    assign key_alarm = key && !ign && sw[IN_DRV];

    // Dome and foot light dimming. The ramp is a stepped PWM duty, not an analog slope.
    bct_dim_e         dim_q;
    logic [PWM_W-1:0] level_q;
    logic [TMR_W-1:0] step_cnt_q;
    logic [PWM_W-1:0] pwm_cnt_q;
    logic             pwm_on;

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            dim_q <= DIM_IDLE;
        else
            case (dim_q)
                DIM_IDLE:
                    if (any_open)
                        dim_q <= DIM_LIT;
                DIM_LIT:
                    if (all_closed)
                        dim_q <= ign ? DIM_IDLE : DIM_RAMP;
                DIM_RAMP:
                    if (any_open)
                        dim_q <= DIM_LIT;
                    else if (ign || level_q == DIM_OFF)
                        dim_q <= DIM_IDLE;
                default:
                    dim_q <= DIM_IDLE;
            endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            level_q    <= DIM_OFF;
            step_cnt_q <= '0;
        end
        else if (dim_q != DIM_RAMP)
        begin
            level_q    <= DIM_FULL;
            step_cnt_q <= '0;
        end
        else if (step_cnt_q >= P_DIM_STEP_CYC - 1'b1)
        begin
            step_cnt_q <= '0;
            if (level_q != DIM_OFF)
                level_q <= level_q - 1'b1;
        end
        else
            step_cnt_q <= step_cnt_q + 1'b1;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            pwm_cnt_q <= '0;
        else
            pwm_cnt_q <= pwm_cnt_q + 1'b1;
    end

    assign pwm_on = (dim_q == DIM_RAMP) && !ign && (pwm_cnt_q < level_q);

    // All lamp and driver outputs are registered to keep glitches off the relays.
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            unlock_driver_output_o           <= 1'b0;
            lock_or_lamp_driver_output_o     <= 1'b0;
            unlock_or_buzzer_driver_output_o <= 1'b0;
            buzzer_o                         <= 1'b0;
            ign_illum_o                      <= 1'b0;
            dome_light_o                     <= 1'b0;
            foot_light_o                     <= 1'b0;
            defog_relay_o                    <= 1'b0;
            belt_light_o                     <= 1'b0;
        end
        else
        begin
            unlock_driver_output_o           <= unlock_long_run;
            lock_or_lamp_driver_output_o     <= lock_run;
            unlock_or_buzzer_driver_output_o <= unlock_short_run;
            buzzer_o                         <= buzz_q && (key_alarm || (belt_buzz_run && ign));
            ign_illum_o                      <= illum_run && !ign;
            dome_light_o                     <= sw[IN_DSEL] && ((any_open) || pwm_on);
            foot_light_o                     <= foot_zone_open || pwm_on;
            defog_relay_o                    <= defog_run && ign;
            belt_light_o                     <= belt_light_run && blink_q && ign;
        end
    end
endmodule
`default_nettype wire

/* test/bct_timers_asserts.sv */
// Checker for the body control timers, bound to the top module.
// Assumes the shortened timer counts are handed on by the bind.
`timescale 1ns/1ps
`default_nettype none
module bct_timers_asserts
    import bct_pkg::*;
#(
    parameter logic [TMR_W-1:0] P_UNLOCK_LONG_CYC = UNLOCK_LONG_CYC,
    parameter logic [TMR_W-1:0] P_PULSE_CYC       = PULSE_CYC,
    parameter logic [TMR_W-1:0] P_ILLUM_CYC       = ILLUM_CYC
)(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic ign_on_i,
    input wire logic key_in_i,
    input wire logic door_drv_open_i,
    input wire logic door_pass_open_i,
    input wire logic door_rear_open_i,
    input wire logic liftgate_open_i,
    input wire logic dome_door_sel_i,
    input wire logic unlock_driver_output_o,
    input wire logic lock_or_lamp_driver_output_o,
    input wire logic unlock_or_buzzer_driver_output_o,
    input wire logic buzzer_o,
    input wire logic ign_illum_o,
    input wire logic dome_light_o,
    input wire logic foot_light_o,
    input wire logic defog_relay_o,
    input wire logic belt_light_o
);
    // The margin covers sync, debounce, edge, timer and output stages.
    localparam int SETTLE = 14;
    wire              any_open = door_drv_open_i | door_pass_open_i | door_rear_open_i | liftgate_open_i;
    wire        [5:0] cond = {~any_open, door_drv_open_i | door_pass_open_i | liftgate_open_i,
                              any_open & dome_door_sel_i, key_in_i & ~ign_on_i & door_drv_open_i,
                              ~ign_on_i, ign_on_i};
    wire        [3:0] outs = {ign_illum_o, unlock_or_buzzer_driver_output_o,
                              lock_or_lamp_driver_output_o, unlock_driver_output_o};
    logic       [7:0] held_q [6];
    logic [TMR_W-1:0] len_q [4];

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        for (int i = 0; i < 6; i++)
        begin
            if (!rst_n_i || !cond[i])
                held_q[i] <= 8'h00;
            else if (held_q[i] != 8'hff)
                held_q[i] <= held_q[i] + 8'h01;
        end
        for (int i = 0; i < 4; i++)
        begin
            if (!rst_n_i || !outs[i])
                len_q[i] <= '0;
            else
                len_q[i] <= len_q[i] + 1'b1;
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    a_unlock_long_len: assert property ($fell(unlock_driver_output_o) |-> len_q[0] == P_UNLOCK_LONG_CYC)
        else $error("all-door unlock length wrong");
    a_lock_pulse_len: assert property ($fell(lock_or_lamp_driver_output_o) |-> len_q[1] == P_PULSE_CYC)
        else $error("lock pulse length wrong");
    a_unlock_pulse_len: assert property ($fell(unlock_or_buzzer_driver_output_o)
        |-> len_q[2] == P_PULSE_CYC)
        else $error("unlock pulse length wrong");
    a_illum_no_extend: assert property ($fell(ign_illum_o) |-> len_q[3] <= P_ILLUM_CYC)
        else $error("illumination ran too long");
    a_illum_ign_cut: assert property (held_q[0] >= SETTLE |-> !ign_illum_o)
        else $error("illumination on with ignition on");
    a_ign_off_stop: assert property (held_q[1] >= SETTLE |-> !defog_relay_o && !belt_light_o)
        else $error("defogger or belt light on with ignition off");
    a_key_alarm_buzz: assert property (held_q[2] >= SETTLE |-> ##[0:8] buzzer_o)
        else $error("key alarm buzzer silent");
    a_dome_door_on: assert property (held_q[3] >= SETTLE |-> dome_light_o)
        else $error("dome light off with door open");
    a_foot_door_on: assert property (held_q[4] >= SETTLE |-> foot_light_o)
        else $error("foot light off with front door open");
    a_lamps_ign_out: assert property (held_q[0] >= SETTLE && held_q[5] >= SETTLE
        |-> !dome_light_o && !foot_light_o)
        else $error("lamps lit with ignition on and doors shut");
endmodule

bind bct_timers bct_timers_asserts #(
    .P_UNLOCK_LONG_CYC(P_UNLOCK_LONG_CYC),
    .P_PULSE_CYC(P_PULSE_CYC),
    .P_ILLUM_CYC(P_ILLUM_CYC)
) bct_timers_asserts_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ign_on_i(ign_on_i), .key_in_i(key_in_i),
    .door_drv_open_i(door_drv_open_i), .door_pass_open_i(door_pass_open_i),
    .door_rear_open_i(door_rear_open_i), .liftgate_open_i(liftgate_open_i), .dome_door_sel_i(dome_door_sel_i),
    .unlock_driver_output_o(unlock_driver_output_o), .lock_or_lamp_driver_output_o(lock_or_lamp_driver_output_o),
    .unlock_or_buzzer_driver_output_o(unlock_or_buzzer_driver_output_o), .buzzer_o(buzzer_o),
    .ign_illum_o(ign_illum_o), .dome_light_o(dome_light_o), .foot_light_o(foot_light_o),
    .defog_relay_o(defog_relay_o), .belt_light_o(belt_light_o)
);
`default_nettype wire

/* test/bct_vehicle_model.sv */
// Vehicle side model: switch levels and the two door lock actuators.
// Assumes the bench writes switch levels at the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module bct_vehicle_model
    import bct_pkg::*;
(
    input  wire logic            clk_sys_i,
    input  wire logic            lock_all_i,
    input  wire logic            unlock_all_i,
    output logic      [N_IN-1:0] sw_o
);
    logic [N_IN-1:0] sw_q = '0;
    assign sw_o = sw_q;
    // Both actuators follow the unlock drives and the passenger actuator the lock drive, so a lock pulse also locks the passenger side.
    always @(negedge clk_sys_i)
    begin
        if (lock_all_i)
            sw_q[IN_PLOCK] <= 1'b1;
        if (unlock_all_i)
            sw_q[IN_DLOCK] <= 1'b0;
        if (unlock_all_i)
            sw_q[IN_PLOCK] <= 1'b0;
    end
endmodule
`default_nettype wire

/* test/tb_bct_timers.sv */
// Self-checking bench for the body control timers with shortened counts.
// Assumes the vehicle model drives the switches and the checker is bound in.
`timescale 1ns/1ps
`default_nettype none
module tb_bct_timers;
    import bct_pkg::*;
    localparam logic [TMR_W-1:0] T_UNL = 40'h32;
    localparam logic [TMR_W-1:0] T_PUL = 40'h0a;
    localparam logic [TMR_W-1:0] T_ILL = 40'h64;
    localparam logic [TMR_W-1:0] T_DFG = 40'hc8;
    localparam logic [TMR_W-1:0] T_BELT = 40'h30;
    localparam logic [TMR_W-1:0] T_BHALF = 40'h06;
    localparam logic [TMR_W-1:0] T_ZHALF = 40'h03;
    localparam int O_UNL = 0, O_LOCK = 1, O_UNB = 2, O_BUZ = 3, O_ILL = 4;
    localparam int O_DOME = 5, O_FOOT = 6, O_DFG = 7, O_BELT = 8;
    logic                  clk_sys_i = 1'b0;
    logic                  rst_n_i = 1'b0;
    wire logic [N_IN-1:0]  s;
    wire logic [8:0]       o;
    int                    errors = 0;
    int                    comparisons = 0;
    int                    his [9];
    int                    ups [9];

    always #5 clk_sys_i = ~clk_sys_i;

    bct_vehicle_model bct_vehicle_model_inst (.clk_sys_i(clk_sys_i), .lock_all_i(o[O_LOCK]),
        .unlock_all_i(o[O_UNL] | o[O_UNB]), .sw_o(s));

    bct_timers #(.P_DEB_CYC(24'h000004), .P_UNLOCK_LONG_CYC(T_UNL), .P_PULSE_CYC(T_PUL),
        .P_ILLUM_CYC(T_ILL), .P_DIM_STEP_CYC(40'h02), .P_DEFOG_CYC(T_DFG), .P_BELT_CYC(T_BELT),
        .P_BELT_HALF_CYC(T_BHALF), .P_BUZZ_HALF_CYC(T_ZHALF)) bct_timers_inst (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ign_on_i(s[IN_IGN]), .key_in_i(s[IN_KEY]),
        .door_drv_open_i(s[IN_DRV]), .door_pass_open_i(s[IN_PASS]), .door_rear_open_i(s[IN_REAR]),
        .liftgate_open_i(s[IN_LIFT]), .dome_door_sel_i(s[IN_DSEL]), .lock_drv_locked_i(s[IN_DLOCK]),
        .lock_pass_locked_i(s[IN_PLOCK]), .key_cyl_unlock_i(s[IN_KCYL]), .defog_sw_i(s[IN_DEFOG]),
        .belt_buckled_i(s[IN_BUCKLE]), .unlock_driver_output_o(o[O_UNL]),
        .lock_or_lamp_driver_output_o(o[O_LOCK]), .unlock_or_buzzer_driver_output_o(o[O_UNB]),
        .buzzer_o(o[O_BUZ]), .ign_illum_o(o[O_ILL]), .dome_light_o(o[O_DOME]),
        .foot_light_o(o[O_FOOT]), .defog_relay_o(o[O_DFG]), .belt_light_o(o[O_BELT]));

    task automatic tally_and_finish;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [TMR_W-1:0] seen, input logic [TMR_W-1:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: saw %0d expected %0d", $time, seen, exp);
        end
    endtask

    task automatic bit_is(input int k, input logic v);
        check(TMR_W'(o[k]), TMR_W'(v));
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask

    // Callers sit at a falling edge, so switches never move on the sampling edge.
    task automatic put(input int i, input logic v);
        bct_vehicle_model_inst.sw_q[i] = v;
    endtask

    task automatic sw(input int i, input logic v);
        put(i, v);
        cyc(12);
    endtask

    task automatic watch(input int n);
        logic [8:0] prev;
        his = '{default: 0};
        ups = '{default: 0};
        prev = o;
        repeat (n)
        begin
            cyc(1);
            for (int k = 0; k < 9; k++)
            begin
                his[k] += int'(o[k] === 1'b1);
                ups[k] += int'(o[k] === 1'b1 && prev[k] !== 1'b1);
            end
            prev = o;
        end
    endtask

    task automatic pulse_len(input int k, output int len);
        int w = 0;
        len = 0;
        while (o[k] !== 1'b1 && w < 40)
        begin
            cyc(1);
            w++;
        end
        while (o[k] === 1'b1 && len < 1000)
        begin
            cyc(1);
            len++;
        end
    endtask

    task automatic t_locks;
        int len;
        sw(IN_KEY, 1'b1);
        sw(IN_DRV, 1'b1);
        put(IN_DLOCK, 1'b1);
        pulse_len(O_UNL, len);
        check(TMR_W'(len), T_UNL);
        sw(IN_DRV, 1'b0);
        put(IN_DLOCK, 1'b1);
        pulse_len(O_LOCK, len);
        check(TMR_W'(len), T_PUL);
        sw(IN_PLOCK, 1'b0);
        sw(IN_PASS, 1'b1);
        put(IN_PLOCK, 1'b1);
        pulse_len(O_UNL, len);
        check(TMR_W'(len), T_UNL);
        sw(IN_PASS, 1'b0);
        sw(IN_KEY, 1'b0);
        put(IN_KCYL, 1'b1);
        pulse_len(O_UNB, len);
        check(TMR_W'(len), T_PUL);
        sw(IN_KCYL, 1'b0);
        $display("door lock test done");
    endtask

    task automatic t_illum_belt;
        int nb;
        nb = int'(T_BELT / (2 * T_ZHALF));
        cyc(120);
        put(IN_DRV, 1'b1);
        cyc(20);
        sw(IN_DRV, 1'b0);
        sw(IN_DRV, 1'b1);
        cyc(int'(T_ILL) - 49);
        bit_is(O_ILL, 1'b1);
        cyc(20);
        bit_is(O_ILL, 1'b0);
        sw(IN_DRV, 1'b0);
        sw(IN_DRV, 1'b1);
        put(IN_IGN, 1'b1);
        watch(80);
        bit_is(O_ILL, 1'b0);
        check(TMR_W'(ups[O_BELT]), T_BELT / (2 * T_BHALF));
        check(TMR_W'(ups[O_BUZ] >= nb - 1 && ups[O_BUZ] <= nb + 1), 40'h1);
        sw(IN_IGN, 1'b0);
        sw(IN_IGN, 1'b1);
        sw(IN_BUCKLE, 1'b1);
        put(IN_IGN, 1'b0);
        watch(20);
        check(TMR_W'(his[O_BUZ]), 40'h0);
        watch(20);
        check(TMR_W'(his[O_BELT]), 40'h0);
        sw(IN_BUCKLE, 1'b0);
        $display("illumination and belt test done");
    endtask

    task automatic t_defog;
        sw(IN_DEFOG, 1'b1);
        sw(IN_DEFOG, 1'b0);
        bit_is(O_DFG, 1'b0);
        sw(IN_IGN, 1'b1);
        put(IN_DEFOG, 1'b1);
        cyc(2);
        sw(IN_DEFOG, 1'b0);
        bit_is(O_DFG, 1'b0);
        sw(IN_DEFOG, 1'b1);
        sw(IN_DEFOG, 1'b0);
        cyc(int'(T_DFG) - 19);
        bit_is(O_DFG, 1'b1);
        cyc(10);
        bit_is(O_DFG, 1'b0);
        sw(IN_DEFOG, 1'b1);
        sw(IN_DEFOG, 1'b0);
        cyc(30);
        bit_is(O_DFG, 1'b1);
        sw(IN_DEFOG, 1'b1);
        sw(IN_DEFOG, 1'b0);
        bit_is(O_DFG, 1'b0);
        sw(IN_DEFOG, 1'b1);
        sw(IN_DEFOG, 1'b0);
        sw(IN_IGN, 1'b0);
        bit_is(O_DFG, 1'b0);
        $display("defogger test done");
    endtask

    task automatic t_lamps;
        sw(IN_DRV, 1'b0);
        cyc(600);
        sw(IN_DSEL, 1'b1);
        sw(IN_REAR, 1'b1);
        bit_is(O_DOME, 1'b1);
        sw(IN_PASS, 1'b1);
        sw(IN_DSEL, 1'b0);
        bit_is(O_FOOT, 1'b1);
        sw(IN_REAR, 1'b0);
        sw(IN_PASS, 1'b0);
        watch(400);
        check(TMR_W'(his[O_FOOT] > 50 && his[O_FOOT] < 350), 40'h1);
        cyc(200);
        watch(256);
        check(TMR_W'(his[O_FOOT]), 40'h0);
        sw(IN_DSEL, 1'b1);
        sw(IN_PASS, 1'b1);
        sw(IN_PASS, 1'b0);
        put(IN_IGN, 1'b1);
        cyc(14);
        watch(256);
        check(TMR_W'(his[O_FOOT] + his[O_DOME]), 40'h0);
        sw(IN_IGN, 1'b0);
        sw(IN_KEY, 1'b1);
        put(IN_DRV, 1'b1);
        watch(30);
        check(TMR_W'(ups[O_BUZ] > 0), 40'h1);
        sw(IN_KEY, 1'b0);
        watch(20);
        check(TMR_W'(his[O_BUZ]), 40'h0);
        $display("lamp and key alarm test done");
    endtask

    initial
    begin
        cyc(10);
        rst_n_i = 1'b1;
        cyc(2);
        check({31'h0, o}, 40'h0);
        t_locks();
        t_illum_belt();
        t_defog();
        t_lamps();
        tally_and_finish();
    end

    // Whole run needs about 3000 cycles; the limit leaves ample room.
    initial
    begin
        cyc(20000);
        errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
